//--- core/cbf_top.sv
// cache write ordering: barriers, flushes, commit engine, config bytes
`default_nettype none
`include "cbf_params.svh"
module cbf_top (
  input  wire logic                   clk_sys,    // system clock 100 MHz
  input  wire logic                   rst_b,      // async reset, low
  input  wire logic                   ce,         // clock enable
  input  wire logic                   linkClk,    // host bus clock pin
  input  wire logic                   hwRst_b,    // hardware reset pin, low
  input  wire cbf_pkg::cbf_host_req_t hostReq,    // host request pins
  input  wire logic                   nandDone,   // storage program done
  input  wire logic                   nandErr,    // storage program failed
  output logic                        nandProg,   // start program pulse
  output logic      [`CBF_ADDR_W-1:0] nandAddr,   // address to program
  output logic      [7:0]             cfgRdData,  // config byte read data
  output logic                        busy,       // busy to host
  output logic                        statusErr   // cached program error status
);
  // ==========================================================
  // pin synchronisers
  logic [2:0]             lnkS_q;     // host clock samples
  logic [1:0]             hwS_q;      // reset pin samples
  cbf_pkg::cbf_host_req_t reqS1_q;    // request first stage
  cbf_pkg::cbf_host_req_t reqS2_q;    // request second stage

  // two stages before use, third only for edge finding
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lnkS_q  <= 3'h0;
      hwS_q   <= 2'h0;
      reqS1_q <= '0;
      reqS2_q <= '0;
    end else if (ce) begin
      lnkS_q  <= {lnkS_q[1:0], linkClk};
      hwS_q   <= {hwS_q[0], hwRst_b};
      reqS1_q <= hostReq;
      reqS2_q <= reqS1_q;
    end
  end

  // ==========================================================
  // event decode
  logic                   hostEvt;    // host clock rising edge seen
  logic                   softRst;    // pin or go-idle reset
  logic                   cfgW;       // config write event
  logic                   fenceWr;    // fence bit written
  logic                   fenceOk;    // fences usable
  logic                   fenceAcc;   // barrier taken
  logic                   fenceOver;  // barrier beyond tracking
  logic                   flushWr;    // flush bit written
  logic                   cacheOffWr; // cache switched off
  logic                   flushSet;   // start full flush
  logic                   flushDone;  // full flush finished
  logic                   wrAcc;      // host write taken
  logic                   startDir;   // direct program start
  logic                   startFifo;  // cached program start
  logic                   idleHit;    // lazy commit time reached
  logic                   fifoEmpty;  // store empty
  logic                   fifoFull;   // store full
  logic                   fifoPush;   // move pending into store
  logic [`CBF_ADDR_W-1:0] headAddr;   // oldest cached address

  // state
  logic                   cacheOn_q;   // cache enabled
  logic [7:0]             fenceEn_q;   // fence enable byte
  logic [3:0]             fenceCnt_q;  // barriers held since flush
  logic                   flushAct_q;  // full flush running
  logic                   pendValid_q; // write waiting for store or direct program
  logic                   pendDir_q;   // waiting write bypasses cache
  logic [`CBF_ADDR_W-1:0] pendAddr_q;  // waiting write address
  logic                   progCach_q;  // program is cached data
  logic [7:0]             idleCnt_q;   // cycles without host writes
  cbf_pkg::cbf_state_t    state_q;     // commit engine state

  assign hostEvt    = lnkS_q[1] & ~lnkS_q[2];
  assign softRst    = ~hwS_q[1] | (hostEvt & reqS2_q.goIdle);
  assign cfgW       = hostEvt & reqS2_q.cfgWr & ~softRst;
  assign fenceWr    = cfgW & (reqS2_q.cfgIdx == `CBF_IDX_COMMIT_CTL)
                    & reqS2_q.cfgData[`CBF_BIT_FENCE];
  assign fenceOk    = fenceEn_q[`CBF_BIT_EN] & (`CBF_FENCE_CAP_VAL != 8'h00);
  assign fenceAcc   = fenceWr & fenceOk;
  assign fenceOver  = fenceAcc & (fenceCnt_q == `CBF_FENCE_MAX - 4'h1);
  assign flushWr    = cfgW & (reqS2_q.cfgIdx == `CBF_IDX_COMMIT_CTL)
                    & reqS2_q.cfgData[`CBF_BIT_FLUSH];
  assign cacheOffWr = cfgW & (reqS2_q.cfgIdx == `CBF_IDX_CACHE_ON)
                    & ~reqS2_q.cfgData[0] & cacheOn_q;
  assign flushSet   = flushWr | cacheOffWr | fenceOver | softRst;
  assign flushDone  = flushAct_q & fifoEmpty & ~pendValid_q
                    & (state_q == cbf_pkg::CBF_ST_IDLE) & ~flushSet;
  assign wrAcc      = hostEvt & reqS2_q.wrValid & ~pendValid_q & ~softRst;
  assign fifoPush   = pendValid_q & ~pendDir_q & ~fifoFull;
  assign idleHit    = (idleCnt_q == 8'(`CBF_IDLE_CYC));
  assign startDir   = (state_q == cbf_pkg::CBF_ST_IDLE) & pendValid_q & pendDir_q;
  assign startFifo  = (state_q == cbf_pkg::CBF_ST_IDLE) & ~startDir & ~fifoEmpty
                    & (flushAct_q | fifoFull | idleHit);

  // ==========================================================
  // config bytes written by host
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cacheOn_q <= 1'b0;
      fenceEn_q <= 8'h00;
    end else if (ce) begin
      if (softRst) begin
        cacheOn_q <= 1'b0;
        fenceEn_q <= 8'h00;
      end else if (cfgW && reqS2_q.cfgIdx == `CBF_IDX_CACHE_ON) begin
        cacheOn_q <= reqS2_q.cfgData[0];
      end else if (cfgW && reqS2_q.cfgIdx == `CBF_IDX_FENCE_EN) begin
        fenceEn_q <= reqS2_q.cfgData;
      end
    end
  end

  // barrier tracking and full flush, a start wins over an end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fenceCnt_q <= 4'h0;
      flushAct_q <= 1'b0;
    end else if (ce) begin
      if (softRst) fenceCnt_q <= 4'h0;
      // a barrier in the cycle a flush ends starts a fresh count of one
      else if (fenceAcc && !fenceOver) begin
        fenceCnt_q <= flushDone ? 4'h1 : fenceCnt_q + 4'h1;
      end
      else if (flushDone) fenceCnt_q <= 4'h0;
      if (flushSet) flushAct_q <= 1'b1;
      else if (flushDone) flushAct_q <= 1'b0;
    end
  end

  // pending host write, bypass when cache off or forced
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pendValid_q <= 1'b0;
      pendDir_q   <= 1'b0;
      pendAddr_q  <= 16'h0000;
    end else if (ce) begin
      if (wrAcc) begin
        pendValid_q <= 1'b1;
        pendDir_q   <= ~cacheOn_q | reqS2_q.wrForce;
        pendAddr_q  <= reqS2_q.wrAddr;
      end else if (fifoPush || startDir) begin
        pendValid_q <= 1'b0;
      end
    end
  end

  // lazy commit timer, restarts on each host write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) idleCnt_q <= 8'h00;
    else if (ce) begin
      if (wrAcc || fifoEmpty) idleCnt_q <= 8'h00;
      else if (!idleHit) idleCnt_q <= idleCnt_q + 8'h01;
    end
  end

  // ==========================================================
  // commit engine, one program at a time, store drains oldest first
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= cbf_pkg::CBF_ST_IDLE;
      nandProg   <= 1'b0;
      nandAddr   <= 16'h0000;
      progCach_q <= 1'b0;
    end else if (ce) begin
      nandProg <= 1'b0;
      case (state_q)
        cbf_pkg::CBF_ST_IDLE: begin
          if (startDir || startFifo) begin
            nandProg   <= 1'b1;
            nandAddr   <= startDir ? pendAddr_q : headAddr;
            progCach_q <= startFifo;
            state_q    <= cbf_pkg::CBF_ST_PROG;
          end
        end
        cbf_pkg::CBF_ST_PROG: begin
          if (nandDone) state_q <= cbf_pkg::CBF_ST_IDLE;
        end
        default: state_q <= cbf_pkg::CBF_ST_IDLE;
      endcase
    end
  end

  // error status, a failure wins over a new flush request
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) statusErr <= 1'b0;
    else if (ce) begin
      if (state_q == cbf_pkg::CBF_ST_PROG && nandDone && nandErr && progCach_q)
        statusErr <= 1'b1;
      else if (flushWr || softRst) statusErr <= 1'b0;
    end
  end

  // busy to host and config byte reads
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy      <= 1'b0;
      cfgRdData <= 8'h00;
    end else if (ce) begin
      busy <= pendValid_q | flushAct_q | (state_q == cbf_pkg::CBF_ST_PROG);
      if (hostEvt && reqS2_q.cfgRd) begin
        case (reqS2_q.cfgIdx)
          `CBF_IDX_FENCE_EN:   cfgRdData <= fenceEn_q;
          `CBF_IDX_COMMIT_CTL: cfgRdData <= {7'h00, flushAct_q};
          `CBF_IDX_CACHE_ON:   cfgRdData <= {7'h00, cacheOn_q};
          `CBF_IDX_POLICY:     cfgRdData <= `CBF_POLICY_VAL;
          `CBF_IDX_FENCE_CAP:  cfgRdData <= `CBF_FENCE_CAP_VAL;
          default:             cfgRdData <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // cached write store
  cbf_commit_fifo uStore (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .ce       (ce),
    .push     (fifoPush),
    .pushData (pendAddr_q),
    .pop      (startFifo),
    .headData (headAddr),
    .empty    (fifoEmpty),
    .full     (fifoFull)
  );

  // ==========================================================
  // checks, written for ce held high
  property p_overFlush;
    @(posedge clk_sys) disable iff (!rst_b) ce && fenceOver |=> flushAct_q;
  endproperty
  a_overFlush: assert property (p_overFlush)
    else $error("barrier overflow did not start flush");
  property p_offFlush;
    @(posedge clk_sys) disable iff (!rst_b)
      ce && cacheOffWr |=> flushAct_q && !cacheOn_q;
  endproperty
  a_offFlush: assert property (p_offFlush)
    else $error("cache off did not flush");
  property p_resetOff;
    @(posedge clk_sys) disable iff (!rst_b)
      ce && softRst |=> !cacheOn_q && fenceEn_q == 8'h00 && fenceCnt_q == 4'h0;
  endproperty
  a_resetOff: assert property (p_resetOff)
    else $error("cache still on after reset");
  property p_doneClear;
    @(posedge clk_sys) disable iff (!rst_b) $fell(flushAct_q) |-> fenceCnt_q <= 4'h1;
  endproperty
  a_doneClear: assert property (p_doneClear)
    else $error("barrier state kept after flush");
  property p_fenceIgnored;
    @(posedge clk_sys) disable iff (!rst_b)
      ce && fenceWr && !fenceEn_q[0] && !softRst && !flushDone |=> $stable(fenceCnt_q);
  endproperty
  a_fenceIgnored: assert property (p_fenceIgnored)
    else $error("disabled barrier changed tracking");
  property p_fenceCount;
    @(posedge clk_sys) disable iff (!rst_b)
      ce && fenceAcc && !fenceOver && !flushDone |=> fenceCnt_q == $past(fenceCnt_q) + 4'h1;
  endproperty
  a_fenceCount: assert property (p_fenceCount)
    else $error("barrier not recorded");
  property p_policyRead;
    @(posedge clk_sys) disable iff (!rst_b)
      ce && hostEvt && reqS2_q.cfgRd && reqS2_q.cfgIdx == `CBF_IDX_POLICY
      |=> cfgRdData == `CBF_POLICY_VAL;
  endproperty
  a_policyRead: assert property (p_policyRead)
    else $error("policy byte changed");
  property p_capRead;
    @(posedge clk_sys) disable iff (!rst_b)
      ce && hostEvt && reqS2_q.cfgRd && reqS2_q.cfgIdx == `CBF_IDX_FENCE_CAP
      |=> cfgRdData == 8'h01;
  endproperty
  a_capRead: assert property (p_capRead)
    else $error("capability byte wrong");
  property p_fullDrains;
    @(posedge clk_sys) disable iff (!rst_b)
      ce && fifoFull && state_q == cbf_pkg::CBF_ST_IDLE && !pendDir_q |=> nandProg;
  endproperty
  a_fullDrains: assert property (p_fullDrains)
    else $error("full cache not drained");
  property p_errReport;
    @(posedge clk_sys) disable iff (!rst_b)
      ce && state_q == cbf_pkg::CBF_ST_PROG && nandDone && nandErr && progCach_q
      |=> statusErr;
  endproperty
  a_errReport: assert property (p_errReport)
    else $error("cached program error not reported");
  c_fence: cover property (@(posedge clk_sys) disable iff (!rst_b) fenceAcc);
  c_over: cover property (@(posedge clk_sys) disable iff (!rst_b) fenceOver);
  c_done: cover property (@(posedge clk_sys) disable iff (!rst_b) flushDone);
  c_direct: cover property (@(posedge clk_sys) disable iff (!rst_b) startDir && !fifoEmpty);
endmodule
`default_nettype wire

//--- core/cbf_params.svh
// constants of the cache barrier and commit ordering block
`ifndef CBF_PARAMS_SVH
`define CBF_PARAMS_SVH
// ==========================================================
// extended config block indices
`define CBF_IDX_FENCE_EN   9'h01f
`define CBF_IDX_COMMIT_CTL 9'h020
`define CBF_IDX_CACHE_ON   9'h021
`define CBF_IDX_POLICY     9'h0f0
`define CBF_IDX_FENCE_CAP  9'h1e6
// ==========================================================
// field positions and constant byte values
`define CBF_BIT_FLUSH      0
`define CBF_BIT_FENCE      1
`define CBF_BIT_EN         0
`define CBF_FENCE_CAP_VAL  8'h01
`define CBF_POLICY_VAL     8'h01
// ==========================================================
// sizes and timing
`define CBF_DEPTH          4'h8
`define CBF_PTR_W          3
`define CBF_ADDR_W         16
`define CBF_FENCE_MAX      4'h8
`define CBF_CLK_NS         10
`define CBF_IDLE_NS        500
`define CBF_IDLE_CYC       (`CBF_IDLE_NS / `CBF_CLK_NS)
`endif

//--- core/cbf_pkg.sv
// types of the cache barrier and commit ordering block
`default_nettype none
package cbf_pkg;
  // host request sampled at a host bus clock rising edge
  typedef struct packed {
    logic        goIdle;   // go-idle command
    logic        wrValid;  // write request
    logic        wrForce;  // forced or reliable write
    logic [15:0] wrAddr;   // write block address
    logic        cfgWr;    // config byte write
    logic        cfgRd;    // config byte read
    logic [8:0]  cfgIdx;   // config byte index
    logic [7:0]  cfgData;  // config write data
  } cbf_host_req_t;
  // commit engine states
  typedef enum logic [0:0] {
    CBF_ST_IDLE = 1'b0,
    CBF_ST_PROG = 1'b1
  } cbf_state_t;
endpackage
`default_nettype wire

//--- core/cbf_commit_fifo.sv
// in-order store of cached write addresses awaiting commit
`default_nettype none
`include "cbf_params.svh"
module cbf_commit_fifo (
  input  wire logic                   clk_sys,  // system clock
  input  wire logic                   rst_b,    // async reset, low
  input  wire logic                   ce,       // clock enable
  input  wire logic                   push,     // store one entry
  input  wire logic [`CBF_ADDR_W-1:0] pushData, // address stored
  input  wire logic                   pop,      // drop head entry
  output logic      [`CBF_ADDR_W-1:0] headData, // oldest entry
  output logic                        empty,    // no entries
  output logic                        full      // no room
);
  // ==========================================================
  // pointers and count
  logic [`CBF_PTR_W-1:0]   wrPtr_q;          // next free slot
  logic [`CBF_PTR_W-1:0]   rdPtr_q;          // oldest slot
  logic [`CBF_PTR_W:0]     count_q;          // entries held
  logic [`CBF_ADDR_W-1:0]  mem_q [`CBF_DEPTH]; // entry storage

  assign empty    = (count_q == 4'h0);
  assign full     = (count_q == `CBF_DEPTH);
  assign headData = mem_q[rdPtr_q];

  // pointer and count update, oldest leaves first
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q <= 3'h0;
      rdPtr_q <= 3'h0;
      count_q <= 4'h0;
    end else if (ce) begin
      if (push) wrPtr_q <= wrPtr_q + 3'h1;
      if (pop) rdPtr_q <= rdPtr_q + 3'h1;
      count_q <= count_q + {3'h0, push} - {3'h0, pop};
    end
  end

  // ==========================================================
  // one storage slot per entry
  for (genvar gi = 0; gi < `CBF_DEPTH; gi++) begin : gSlot
    always_ff @(posedge clk_sys) begin
      if (ce && push && wrPtr_q == `CBF_PTR_W'(gi)) mem_q[gi] <= pushData;
    end
  end

  // ==========================================================
  // checks
  property p_noOverflow;
    @(posedge clk_sys) disable iff (!rst_b) ce && full |-> !push;
  endproperty
  a_noOverflow: assert property (p_noOverflow)
    else $error("push into full commit store");
  property p_countBound;
    @(posedge clk_sys) disable iff (!rst_b) count_q <= `CBF_DEPTH;
  endproperty
  a_countBound: assert property (p_countBound)
    else $error("commit store count out of range");
endmodule
`default_nettype wire

//--- bench/cbf_host_model.sv
// host controller model: frames requests on the host bus clock
`default_nettype none
`include "cbf_params.svh"
module cbf_host_model (
  input  wire logic                    clk_sys,   // system clock, paces frames
  input  wire logic [7:0]              cfgRdData, // config read result
  input  wire logic                    busy,      // device busy
  output var  logic                    linkClk,   // host bus clock, still between frames
  output var  cbf_pkg::cbf_host_req_t  hostReq    // request lines
);
  timeunit 1ns;
  timeprecision 100ps;
  cbf_pkg::cbf_host_req_t lastReq; // last request framed
  // lines idle and clock still at start
  initial begin
    linkClk = 1'b0;
    hostReq = '0;
    lastReq = '0;
  end
  // ============================================================
  // frame: 40 ns setup, 40 ns high, release at fall, 40 ns low
  task automatic frame(input cbf_pkg::cbf_host_req_t req);
    cbf_pkg::cbf_host_req_t idle;
    @(negedge clk_sys);
    hostReq = req;
    lastReq = req;
    repeat (4) @(negedge clk_sys);
    linkClk = 1'b1;
    repeat (4) @(negedge clk_sys);
    linkClk = 1'b0;
    // released lines show the inverse, strobes low
    idle         = ~lastReq;
    idle.goIdle  = 1'b0;
    idle.wrValid = 1'b0;
    idle.cfgWr   = 1'b0;
    idle.cfgRd   = 1'b0;
    hostReq      = idle;
    repeat (4) @(negedge clk_sys);
  endtask
  // bounded wait for busy low before the next write
  task automatic waitIdle();
    for (int n = 0; n < 2000 && busy !== 1'b0; n++) @(negedge clk_sys);
  endtask
  // config byte write
  task automatic cfgWrite(input logic [8:0] idx, input logic [7:0] data);
    cbf_pkg::cbf_host_req_t r;
    r = '0;
    r.cfgWr = 1'b1;
    r.cfgIdx = idx;
    r.cfgData = data;
    frame(r);
  endtask
  // config byte read, result taken after the answer settles
  task automatic cfgRead(input logic [8:0] idx, output logic [7:0] data);
    cbf_pkg::cbf_host_req_t r;
    r = '0;
    r.cfgRd = 1'b1;
    r.cfgIdx = idx;
    frame(r);
    data = cfgRdData;
  endtask
  // ordering fence; only sent to probe acceptance on an in-order device
  task automatic fence();
    cfgWrite(`CBF_IDX_COMMIT_CTL, 8'h02);
  endtask
  // fence enable before any fence use
  task automatic fenceEnable(input logic [7:0] v);
    cfgWrite(`CBF_IDX_FENCE_EN, v);
  endtask
  // block write; caller flushes first when forced order matters
  task automatic hostWrite(input logic [15:0] addr, input logic force_);
    cbf_pkg::cbf_host_req_t r;
    waitIdle();
    r = '0;
    r.wrValid = 1'b1;
    r.wrForce = force_;
    r.wrAddr = addr;
    frame(r);
  endtask
  // go-idle command
  task automatic goIdleCmd();
    cbf_pkg::cbf_host_req_t r;
    r = '0;
    r.goIdle = 1'b1;
    frame(r);
  endtask
endmodule
`default_nettype wire

//--- bench/tb_cbf_top.sv
// self-checking bench of the cache write ordering block
`default_nettype none
`include "cbf_params.svh"
module tb_cbf_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                   clk_sys, rst_b, ce, linkClk, hwRst_b;   // clock, resets, pins
  logic                   nandDone, nandErr, nandProg, busy, statusErr; // storage, status
  cbf_pkg::cbf_host_req_t hostReq;    // host request lines
  logic [15:0]            nandAddr;   // programmed address
  logic [7:0]             cfgRdData;  // config read data
  logic [7:0]             rd;         // read result
  int                     failures;   // mismatches
  int                     checks;     // comparisons
  int                     cycles;     // timeout count
  int                     lagCyc;     // storage answer delay
  logic                   errNext;    // next program fails
  logic [15:0]            commitLog[$]; // program order seen
  logic [15:0]            expQ[$];      // expected order
  logic [8:0]             idxTab[5] = '{9'h1e6, 9'h0f0, 9'h021, 9'h01f, 9'h100}; // reset reads
  logic [7:0]             expTab[5] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00};      // expected
  cbf_top i_cbf_top (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .linkClk(linkClk),
    .hwRst_b(hwRst_b), .hostReq(hostReq), .nandDone(nandDone), .nandErr(nandErr),
    .nandProg(nandProg), .nandAddr(nandAddr), .cfgRdData(cfgRdData), .busy(busy),
    .statusErr(statusErr));
  cbf_host_model i_cbf_host_model (.clk_sys(clk_sys), .cfgRdData(cfgRdData), .busy(busy),
    .linkClk(linkClk), .hostReq(hostReq));
  // ============================================================
  // clock and timeout
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      close_out();
    end
  end
  // storage responder: logs program starts, answers after lagCyc cycles
  initial begin
    nandDone = 1'b0;
    nandErr = 1'b0;
    forever begin
      @(negedge clk_sys);
      if (nandProg === 1'b1) begin
        commitLog.push_back(nandAddr);
        repeat (lagCyc) @(negedge clk_sys);
        nandDone = 1'b1;
        nandErr = errNext;
        @(negedge clk_sys);
        nandDone = 1'b0;
        nandErr = 1'b0;
      end
    end
  end
  // ============================================================
  // compare helpers and closing report
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic chkLog();
    chk(16'(commitLog.size()), 16'(expQ.size()));
    foreach (expQ[i]) if (i < commitLog.size()) chk(commitLog[i], expQ[i]);
    commitLog.delete();
    expQ.delete();
  endtask
  // busy drops for a cycle between lazy programs, so wait for a quiet stretch
  task automatic settle();
    int quiet;
    quiet = 0;
    repeat (70) @(negedge clk_sys);
    for (int n = 0; n < 2000 && quiet < 8; n++) begin
      @(negedge clk_sys);
      quiet = (busy === 1'b0) ? quiet + 1 : 0;
    end
  endtask
  task automatic close_out();
    $display("checks %0d, failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ============================================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    hwRst_b = 1'b1;
    lagCyc = 3;
    errNext = 1'b0;
    failures = 0;
    checks = 0;
    cycles = 0;
    repeat (6) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (10) @(negedge clk_sys);
    // config bytes after reset, read-only bytes ignore writes
    foreach (idxTab[i]) begin
      i_cbf_host_model.cfgRead(idxTab[i], rd);
      chk(16'(rd), 16'(expTab[i]));
    end
    i_cbf_host_model.cfgWrite(`CBF_IDX_POLICY, 8'hfe);
    i_cbf_host_model.cfgWrite(`CBF_IDX_FENCE_CAP, 8'h00);
    i_cbf_host_model.cfgRead(`CBF_IDX_POLICY, rd);
    chk(16'(rd), 16'h0001);
    i_cbf_host_model.cfgRead(`CBF_IDX_FENCE_CAP, rd);
    chk(16'(rd), 16'h0001);
    // cache off: write goes straight to storage
    i_cbf_host_model.hostWrite(16'h0a01, 1'b0);
    repeat (4) @(negedge clk_sys);
    expQ = '{16'h0a01};
    chkLog();
    // fence between cached writes, slow storage
    lagCyc = 12;
    i_cbf_host_model.fenceEnable(8'h01);
    i_cbf_host_model.cfgWrite(`CBF_IDX_CACHE_ON, 8'h01);
    i_cbf_host_model.hostWrite(16'h0a02, 1'b0);
    i_cbf_host_model.hostWrite(16'h0a03, 1'b0);
    i_cbf_host_model.fence();
    i_cbf_host_model.hostWrite(16'h0a04, 1'b0);
    settle();
    expQ = '{16'h0a02, 16'h0a03, 16'h0a04};
    chkLog();
    chk(16'(statusErr), 16'h0000);
    // more fences than tracked turn into a full flush
    i_cbf_host_model.hostWrite(16'h0a05, 1'b0);
    for (int i = 0; i < 9; i++) i_cbf_host_model.fence();
    i_cbf_host_model.hostWrite(16'h0a06, 1'b0);
    settle();
    expQ = '{16'h0a05, 16'h0a06};
    chkLog();
    chk(16'(statusErr), 16'h0000);
    // store overfilled with fast storage
    lagCyc = 2;
    for (int i = 0; i < 9; i++) begin
      i_cbf_host_model.hostWrite(16'h0b00 + 16'(i), 1'b0);
      expQ.push_back(16'h0b00 + 16'(i));
    end
    settle();
    chkLog();
    // forced write overtakes cached data
    i_cbf_host_model.hostWrite(16'h0c01, 1'b0);
    i_cbf_host_model.hostWrite(16'h0c02, 1'b1);
    settle();
    expQ = '{16'h0c02, 16'h0c01};
    chkLog();
    // cache switched off flushes before the idle commit
    i_cbf_host_model.hostWrite(16'h0d01, 1'b0);
    i_cbf_host_model.cfgWrite(`CBF_IDX_CACHE_ON, 8'h00);
    repeat (6) @(negedge clk_sys);
    expQ = '{16'h0d01};
    chkLog();
    // failed program sets status, flush request clears it
    i_cbf_host_model.cfgWrite(`CBF_IDX_CACHE_ON, 8'h01);
    errNext = 1'b1;
    i_cbf_host_model.hostWrite(16'h0e01, 1'b0);
    settle();
    errNext = 1'b0;
    chk(16'(statusErr), 16'h0001);
    i_cbf_host_model.cfgWrite(`CBF_IDX_COMMIT_CTL, 8'h01);
    settle();
    chk(16'(statusErr), 16'h0000);
    expQ = '{16'h0e01};
    chkLog();
    // fence with enable clear has no effect
    i_cbf_host_model.fenceEnable(8'h00);
    i_cbf_host_model.hostWrite(16'h0f01, 1'b0);
    i_cbf_host_model.fence();
    i_cbf_host_model.hostWrite(16'h0f02, 1'b0);
    settle();
    expQ = '{16'h0f01, 16'h0f02};
    chkLog();
    // go-idle flushes and clears cache on and fence enable
    i_cbf_host_model.fenceEnable(8'h01);
    i_cbf_host_model.hostWrite(16'h1001, 1'b0);
    i_cbf_host_model.goIdleCmd();
    repeat (8) @(negedge clk_sys);
    expQ = '{16'h1001};
    chkLog();
    i_cbf_host_model.cfgRead(`CBF_IDX_CACHE_ON, rd);
    chk(16'(rd), 16'h0000);
    i_cbf_host_model.cfgRead(`CBF_IDX_FENCE_EN, rd);
    chk(16'(rd), 16'h0000);
    // hardware reset pin turns the cache off
    i_cbf_host_model.cfgWrite(`CBF_IDX_CACHE_ON, 8'h01);
    hwRst_b = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(16'(busy), 16'h0001);
    hwRst_b = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk(16'(busy), 16'h0000);
    i_cbf_host_model.cfgRead(`CBF_IDX_CACHE_ON, rd);
    chk(16'(rd), 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
